/* File: verification/cwdp_config_word_decode_protect_tb.sv */
// self-checking bench for the configuration decoder and protection
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, s); end end
module cwdp_config_word_decode_protect_tb;
   logic ref_clk = 1'b0, rst = 1'b1, toolWrStb = 1'b0, toolRdStb = 1'b0, lowVoltEntry = 1'b0, bulkErase = 1'b0;
   logic progAccess = 1'b0, dataAccess = 1'b0, selfWriteReq = 1'b0;
   logic [15:0] toolAddr = 16'h0000, selfWriteAddr = 16'h0000;
   logic [13:0] toolWrData = 14'h0000, toolRdData, memRdData;
   logic progAccessOk, dataAccessOk, selfWriteOk, eraseProgStb, eraseDataStb, clockFailMonitorEn, twoSpeedSwitchoverEn;
   logic clockOutDrive, oscPinsCrystal, resetPinActive, resetPinPullupForced, powerUpDelayEn, dataMemProtect;
   logic programMemProtect, lowVoltageProgEn, debugPinsDedicated, dropTripLow, stackFaultResetEn, freqMultiplierEn;
   logic [1:0] supplyDropResetMode, watchdogMode, selfWriteProtect;
   logic [2:0] clockSourceSelect;
   logic [22:0] cfgAll;
   int error_cnt = 0, cmp_count = 0;
   // op codes: {rst, bulk, write, read, prog, data, self write}
   localparam logic [6:0] RLD = 7'h40, BLK = 7'h20, WR = 7'h10, RD = 7'h08, PRD = 7'h0c, DRD = 7'h0a, SW = 7'h01;
   assign cfgAll = {clockFailMonitorEn, twoSpeedSwitchoverEn, clockOutDrive, oscPinsCrystal, supplyDropResetMode,
      watchdogMode, clockSourceSelect, resetPinActive, resetPinPullupForced, powerUpDelayEn, dataMemProtect,
      programMemProtect, lowVoltageProgEn, debugPinsDedicated, dropTripLow, stackFaultResetEn, freqMultiplierEn,
      selfWriteProtect};
   cwdp_config_word_decode_protect i_cwdp_config_word_decode_protect (.*);
   cwdp_mem_model i_cwdp_mem_model (.*);
   always #25 ref_clk = ~ref_clk;
   // one cycle of any request kind; a one-edge reset reloads the written words
   task automatic op(input logic [15:0] a, input logic [13:0] d, input logic [6:0] k);
      @(posedge ref_clk);
      toolAddr <= a;
      selfWriteAddr <= a;
      toolWrData <= d;
      {rst, bulkErase, toolWrStb, toolRdStb, progAccess, dataAccess, selfWriteReq} <= k;
      @(posedge ref_clk);
      {rst, bulkErase, toolWrStb, toolRdStb, progAccess, dataAccess, selfWriteReq} <= 7'h00;
      #1;
   endtask
   task automatic end_of_test;
      $display("comparisons %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_erased;
      `CHK("erased settings", 23'b1_1_0_0_11_11_111_1_1_0_0_0_1_0_1_1_1_11, cfgAll)
      op(cwdp_pkg::CFG_ONE_ADDR, 14'h0000, RD);
      `CHK("word one", cwdp_pkg::ERASED_WORD, toolRdData)
      op(cwdp_pkg::PART_WORD_ADDR, cwdp_pkg::ZERO_WORD, WR);
      op(cwdp_pkg::PART_WORD_ADDR, 14'h0000, RD);
      `CHK("part word", {cwdp_pkg::PART_CODE, cwdp_pkg::SILICON_STEP}, toolRdData)
      for (int i = 0; i < cwdp_pkg::USER_IDS; i++)
         op(cwdp_pkg::USER_ID_BASE + 16'(i), 14'h0a00 + 14'(i), WR);
      for (int i = 0; i < cwdp_pkg::USER_IDS; i++)
      begin
         op(cwdp_pkg::USER_ID_BASE + 16'(i), 14'h0000, RD);
         `CHK("user id", 14'h0a00 + 14'(i), toolRdData)
      end
      op(16'h0010, 14'h0000, PRD);
      `CHK("open prog read", 14'h2a4a, toolRdData)
      `CHK("open prog grant", 1'b1, progAccessOk)
      op(16'h0020, 14'h0000, DRD);
      `CHK("open data grant", 1'b1, dataAccessOk)
      op(16'h0000, 14'h0000, SW);
      `CHK("self write open", 1'b1, selfWriteOk)
   endtask
   task automatic t_locked;
      op(cwdp_pkg::CFG_ONE_ADDR, 14'h0000, WR);
      op(cwdp_pkg::CFG_TWO_ADDR, 14'h0010, WR); // reserved bit kept at one
      op(cwdp_pkg::CFG_TWO_ADDR, 14'h0000, RD);
      `CHK("word two ones", 14'h08fc, toolRdData)
      op(16'h0000, 14'h0000, RLD);
      `CHK("locked settings", 23'b0_0_0_1_00_00_000_0_0_1_1_1_0_1_0_0_0_00, cfgAll)
      op(16'h0010, 14'h0000, PRD);
      `CHK("locked prog read", 14'h0000, toolRdData)
      `CHK("locked prog grant", 1'b0, progAccessOk)
      op(16'h0020, 14'h0000, DRD);
      `CHK("locked data grant", 1'b0, dataAccessOk)
      op(cwdp_pkg::PROG_LAST, 14'h0000, SW);
      `CHK("self write all", 1'b0, selfWriteOk)
      op(cwdp_pkg::CFG_ONE_ADDR, 14'h0080, WR);
      `CHK("prog erase", 1'b1, eraseProgStb)
      op(16'h0000, 14'h0000, BLK);
      `CHK("data erase", 1'b1, eraseDataStb)
      op(cwdp_pkg::CFG_ONE_ADDR, 14'h0000, RD);
      `CHK("bulk word one", cwdp_pkg::ERASED_WORD, toolRdData)
   endtask
   task automatic t_lowvolt;
      lowVoltEntry <= 1'b1;
      op(cwdp_pkg::CFG_ONE_ADDR, 14'h258c, WR);
      op(cwdp_pkg::CFG_TWO_ADDR, 14'h1711, WR);
      op(cwdp_pkg::CFG_TWO_ADDR, 14'h0000, RD);
      `CHK("refused clear", 14'h3ffd, toolRdData)
      op(16'h0000, 14'h0000, RLD);
      `CHK("low volt settings", 23'b1_0_1_0_10_01_100_1_1_1_0_0_1_0_1_1_1_01, cfgAll)
      op(cwdp_pkg::WRT_LIMIT_MOST, 14'h0000, SW);
      `CHK("self write low", 1'b0, selfWriteOk)
      op(16'h0800, 14'h0000, SW);
      `CHK("self write high", 1'b1, selfWriteOk)
      op(cwdp_pkg::CFG_TWO_ADDR, 14'h3ffe, WR);
      op(16'h0000, 14'h0000, RLD);
      op(cwdp_pkg::WRT_LIMIT_HALF, 14'h0000, SW);
      `CHK("self write half low", 1'b0, selfWriteOk)
      op(16'h0200, 14'h0000, SW);
      `CHK("self write half high", 1'b1, selfWriteOk)
   endtask
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      t_erased;
      t_locked;
      t_lowvolt;
      end_of_test;
   end
   // the whole sequence needs well under a thousand cycles
   initial
   begin
      #(3000 * 50);
      error_cnt++;
      end_of_test;
   end
endmodule
`default_nettype wire

/* File: verification/cwdp_mem_model.sv */
// behavioural memory that answers tool reads behind the protection window
`timescale 1ns/10ps
`default_nettype none
module cwdp_mem_model (
   input wire logic ref_clk,
   input wire logic progAccess,
   input wire logic dataAccess,
   input wire logic [15:0] toolAddr,
   output logic [13:0] memRdData
);
   logic [13:0] idlePat_r = 14'h1555;
   // no access: pattern flips each cycle so a stale word never passes for data
   always @(posedge ref_clk)
   begin
      idlePat_r <= ~idlePat_r;
   end
   assign memRdData = (progAccess || dataAccess) ? (toolAddr[13:0] ^ 14'h2a5a) : idlePat_r;
endmodule
`default_nettype wire

/* File: verification/cwdp_properties.sv */
// assertion checker for the configuration decoder, bound to its top
`timescale 1ns/10ps
`default_nettype none
module cwdp_properties (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [15:0] toolAddr,
   input wire logic toolRdStb,
   input wire logic [13:0] toolRdData,
   input wire logic progAccess,
   input wire logic dataAccess,
   input wire logic [15:0] selfWriteAddr,
   input wire logic selfWriteReq,
   input wire logic progAccessOk,
   input wire logic dataAccessOk,
   input wire logic selfWriteOk,
   input wire logic clockOutDrive,
   input wire logic oscPinsCrystal,
   input wire logic [2:0] clockSourceSelect,
   input wire logic resetPinActive,
   input wire logic programMemProtect,
   input wire logic dataMemProtect,
   input wire logic lowVoltageProgEn,
   input wire logic [1:0] selfWriteProtect
);
   logic progHit;
   logic swExp;
   // outside the program range only a request with dataAccess set takes the data path
   assign progHit = progAccess && toolAddr <= cwdp_pkg::PROG_LAST;
   assign swExp = selfWriteProtect == 2'h3 || (selfWriteProtect == 2'h2 && selfWriteAddr > cwdp_pkg::WRT_LIMIT_HALF)
      || (selfWriteProtect == 2'h1 && selfWriteAddr > cwdp_pkg::WRT_LIMIT_MOST);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_rd(a); toolRdStb && toolAddr == a; endsequence
   property p_part_word; s_rd(cwdp_pkg::PART_WORD_ADDR) |=> toolRdData == {cwdp_pkg::PART_CODE, cwdp_pkg::SILICON_STEP}; endproperty
   a_part_word: assert property (p_part_word) else $error("part word wrong");
   property p_word_two; s_rd(cwdp_pkg::CFG_TWO_ADDR) |=> (toolRdData & cwdp_pkg::C2_FIXED_ONES) == cwdp_pkg::C2_FIXED_ONES; endproperty
   a_word_two: assert property (p_word_two) else $error("word two fixed bits not one");
   property p_prog_zero; toolRdStb && progHit && programMemProtect |=> toolRdData == 14'h0000; endproperty
   a_prog_zero: assert property (p_prog_zero) else $error("protected read not zero");
   property p_prog_ok; progHit |=> progAccessOk == !$past(programMemProtect); endproperty
   a_prog_ok: assert property (p_prog_ok) else $error("program access grant wrong");
   property p_data_ok; dataAccess && !progHit |=> dataAccessOk == !$past(dataMemProtect); endproperty
   a_data_ok: assert property (p_data_ok) else $error("data access grant wrong");
   property p_crystal; oscPinsCrystal == (clockSourceSelect <= cwdp_pkg::high_gain_crystal); endproperty
   a_crystal: assert property (p_crystal) else $error("crystal pins wrong");
   property p_clkout; oscPinsCrystal |-> !clockOutDrive; endproperty
   a_clkout: assert property (p_clkout) else $error("clock out in crystal mode");
   property p_hold; !rst |=> $stable({clockSourceSelect, programMemProtect, dataMemProtect, selfWriteProtect}); endproperty
   a_hold: assert property (p_hold) else $error("settings moved after reset");
   property p_reset_pin; lowVoltageProgEn |-> resetPinActive; endproperty
   a_reset_pin: assert property (p_reset_pin) else $error("reset pin not active");
   property p_self_write; selfWriteReq && selfWriteAddr <= cwdp_pkg::PROG_LAST |=> selfWriteOk == $past(swExp); endproperty
   a_self_write: assert property (p_self_write) else $error("self write grant wrong");
endmodule
bind cwdp_config_word_decode_protect cwdp_properties i_cwdp_properties (.*);
`default_nettype wire

/* File: verilog/cwdp_config_word_decode_protect.sv */
// configuration word store, decoder and external read-out protection
`timescale 1ns/10ps
`default_nettype none
module cwdp_config_word_decode_protect (
   input wire logic ref_clk,
   input wire logic rst,
   // tool port into configuration memory
   input wire logic [15:0] toolAddr,
   input wire logic [13:0] toolWrData,
   input wire logic toolWrStb,
   input wire logic toolRdStb,
   output logic [13:0] toolRdData,
   // programming mode status
   input wire logic lowVoltEntry,
   input wire logic bulkErase,
   // tool requests toward program and data memory
   input wire logic progAccess,
   input wire logic dataAccess,
   input wire logic [13:0] memRdData,
   input wire logic [15:0] selfWriteAddr,
   input wire logic selfWriteReq,
   output logic progAccessOk,
   output logic dataAccessOk,
   output logic selfWriteOk,
   output logic eraseProgStb,
   output logic eraseDataStb,
   // decoded settings
   output logic clockFailMonitorEn,
   output logic twoSpeedSwitchoverEn,
   output logic clockOutDrive,
   output logic oscPinsCrystal,
   output logic [1:0] supplyDropResetMode,
   output logic [1:0] watchdogMode,
   output logic [2:0] clockSourceSelect,
   output logic resetPinActive,
   output logic resetPinPullupForced,
   output logic powerUpDelayEn,
   output logic dataMemProtect,
   output logic programMemProtect,
   output logic lowVoltageProgEn,
   output logic debugPinsDedicated,
   output logic dropTripLow,
   output logic stackFaultResetEn,
   output logic freqMultiplierEn,
   output logic [1:0] selfWriteProtect
);
   logic [13:0] cfgOne_r;
   logic [13:0] cfgTwo_r;
   logic [13:0] userId_r [cwdp_pkg::USER_IDS];
   logic [13:0] cfgTwoWr;
   logic progLock;
   logic dataLock;
   logic progInRange;
   logic selfWriteBlocked;
   logic [1:0] userIdx;
   logic isUserId;
   logic [13:0] rdMux;

   // protection follows the settings latched at reset, not the stored words
   assign progLock = programMemProtect;
   assign dataLock = dataMemProtect;
   assign isUserId = (toolAddr >= cwdp_pkg::USER_ID_BASE) && (toolAddr <= cwdp_pkg::USER_ID_LAST);
   assign userIdx = toolAddr[1:0];

   // low-voltage bit keeps its one when entry was low-voltage
   always_comb
   begin
      cfgTwoWr = toolWrData | cwdp_pkg::C2_FIXED_ONES;
      if (lowVoltEntry)
      begin
         cfgTwoWr[cwdp_pkg::C2_LVP] = cfgTwo_r[cwdp_pkg::C2_LVP] | toolWrData[cwdp_pkg::C2_LVP];
      end
   end

   // storage resets to the erased state; tool writes land at fixed locations
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cfgOne_r <= cwdp_pkg::ERASED_WORD;
         cfgTwo_r <= cwdp_pkg::ERASED_WORD;
      end
      else if (bulkErase)
      begin
         cfgOne_r <= cwdp_pkg::ERASED_WORD;
         cfgTwo_r <= cwdp_pkg::ERASED_WORD;
      end
      else if (toolWrStb)
      begin
         if (toolAddr == cwdp_pkg::CFG_ONE_ADDR)
         begin
            cfgOne_r <= toolWrData;
         end
         if (toolAddr == cwdp_pkg::CFG_TWO_ADDR)
         begin
            cfgTwo_r <= cfgTwoWr;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < cwdp_pkg::USER_IDS; i++)
         begin
            userId_r[i] <= cwdp_pkg::ERASED_WORD;
         end
      end
      else if (toolWrStb && isUserId)
      begin
         userId_r[userIdx] <= toolWrData;
      end
   end

   // program erase on turning code protection off; a bulk erase strobes the erase of each memory whose protection is on
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         eraseProgStb <= 1'b0;
         eraseDataStb <= 1'b0;
      end
      else
      begin
         eraseProgStb <= (progLock && ((toolWrStb && toolAddr == cwdp_pkg::CFG_ONE_ADDR
                          && toolWrData[cwdp_pkg::C1_PROG_PROT_N]) || bulkErase));
         eraseDataStb <= dataLock && bulkErase;
      end
   end

   always_comb
   begin
      rdMux = cwdp_pkg::ZERO_WORD;
      if (isUserId)
      begin
         rdMux = userId_r[userIdx];
      end
      else if (toolAddr == cwdp_pkg::PART_WORD_ADDR)
      begin
         rdMux = {cwdp_pkg::PART_CODE, cwdp_pkg::SILICON_STEP};
      end
      else if (toolAddr == cwdp_pkg::CFG_ONE_ADDR)
      begin
         rdMux = cfgOne_r;
      end
      else if (toolAddr == cwdp_pkg::CFG_TWO_ADDR)
      begin
         rdMux = cfgTwo_r | cwdp_pkg::C2_FIXED_ONES;
      end
      else if (progAccess && toolAddr <= cwdp_pkg::PROG_LAST)
      begin
         // protected program memory reads back as zeros
         rdMux = progLock ? cwdp_pkg::ZERO_WORD : memRdData;
      end
      else if (dataAccess)
      begin
         rdMux = dataLock ? cwdp_pkg::ZERO_WORD : memRdData;
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         toolRdData <= cwdp_pkg::ZERO_WORD;
      end
      else
      begin
         toolRdData <= toolRdStb ? rdMux : cwdp_pkg::ZERO_WORD;
      end
   end

   // gates toward the memories; internal cpu access never passes here
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         progAccessOk <= 1'b0;
         dataAccessOk <= 1'b0;
      end
      else
      begin
         progAccessOk <= progAccess && !progLock;
         dataAccessOk <= dataAccess && !dataLock;
      end
   end

   always_comb
   begin
      progInRange = selfWriteAddr <= cwdp_pkg::PROG_LAST;
      case (selfWriteProtect)
         cwdp_pkg::MODE_ON: selfWriteBlocked = 1'b0;
         cwdp_pkg::MODE_RUN: selfWriteBlocked = selfWriteAddr <= cwdp_pkg::WRT_LIMIT_HALF;
         cwdp_pkg::MODE_SOFT: selfWriteBlocked = selfWriteAddr <= cwdp_pkg::WRT_LIMIT_MOST;
         default: selfWriteBlocked = progInRange;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         selfWriteOk <= 1'b0;
      end
      else
      begin
         selfWriteOk <= selfWriteReq && !selfWriteBlocked;
      end
   end

   // settings are sampled only while reset is high, then held; words reset erased
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         clockFailMonitorEn <= cfgOne_r[cwdp_pkg::C1_FAIL_MON];
         twoSpeedSwitchoverEn <= cfgOne_r[cwdp_pkg::C1_SWITCHOVER];
         oscPinsCrystal <= cfgOne_r[cwdp_pkg::C1_CLK_HI:cwdp_pkg::C1_CLK_LO] <= cwdp_pkg::high_gain_crystal;
         clockOutDrive <= (cfgOne_r[cwdp_pkg::C1_CLK_HI:cwdp_pkg::C1_CLK_LO] > cwdp_pkg::high_gain_crystal)
                          && !cfgOne_r[cwdp_pkg::C1_CLKOUT_N];
         supplyDropResetMode <= cfgOne_r[cwdp_pkg::C1_DROP_HI:cwdp_pkg::C1_DROP_LO];
         dataMemProtect <= ~cfgOne_r[cwdp_pkg::C1_DATA_PROT_N];
         programMemProtect <= ~cfgOne_r[cwdp_pkg::C1_PROG_PROT_N];
         resetPinActive <= cfgTwo_r[cwdp_pkg::C2_LVP] | cfgOne_r[cwdp_pkg::C1_RESET_PIN];
         resetPinPullupForced <= cfgTwo_r[cwdp_pkg::C2_LVP] | cfgOne_r[cwdp_pkg::C1_RESET_PIN];
         powerUpDelayEn <= ~cfgOne_r[cwdp_pkg::C1_PWRUP_N];
         watchdogMode <= cfgOne_r[cwdp_pkg::C1_WDOG_HI:cwdp_pkg::C1_WDOG_LO];
         clockSourceSelect <= cfgOne_r[cwdp_pkg::C1_CLK_HI:cwdp_pkg::C1_CLK_LO];
         lowVoltageProgEn <= cfgTwo_r[cwdp_pkg::C2_LVP];
         debugPinsDedicated <= ~cfgTwo_r[cwdp_pkg::C2_DEBUG_N];
         dropTripLow <= cfgTwo_r[cwdp_pkg::C2_TRIP];
         stackFaultResetEn <= cfgTwo_r[cwdp_pkg::C2_STACK];
         freqMultiplierEn <= cfgTwo_r[cwdp_pkg::C2_PLL];
         selfWriteProtect <= cfgTwo_r[cwdp_pkg::C2_WRT_HI:cwdp_pkg::C2_WRT_LO];
      end
   end
endmodule
`default_nettype wire

/* File: verilog/cwdp_pkg.sv */
// constants for the configuration word decoder and read-out protection block
package cwdp_pkg;
   localparam int WORD_W = 14;
   localparam int ADDR_W = 16;
   // configuration memory locations
   localparam logic [15:0] USER_ID_BASE = 16'h8000;
   localparam logic [15:0] USER_ID_LAST = 16'h8003;
   localparam logic [15:0] PART_WORD_ADDR = 16'h8006;
   localparam logic [15:0] CFG_ONE_ADDR = 16'h8007;
   localparam logic [15:0] CFG_TWO_ADDR = 16'h8008;
   // program memory range reached through the window
   localparam logic [15:0] PROG_LAST = 16'h0fff;
   localparam logic [15:0] WRT_LIMIT_HALF = 16'h01ff;
   localparam logic [15:0] WRT_LIMIT_MOST = 16'h07ff;
   // word one fields
   localparam int C1_FAIL_MON = 13;
   localparam int C1_SWITCHOVER = 12;
   localparam int C1_CLKOUT_N = 11;
   localparam int C1_DROP_HI = 10;
   localparam int C1_DROP_LO = 9;
   localparam int C1_DATA_PROT_N = 8;
   localparam int C1_PROG_PROT_N = 7;
   localparam int C1_RESET_PIN = 6;
   localparam int C1_PWRUP_N = 5;
   localparam int C1_WDOG_HI = 4;
   localparam int C1_WDOG_LO = 3;
   localparam int C1_CLK_HI = 2;
   localparam int C1_CLK_LO = 0;
   // word two fields
   localparam int C2_LVP = 13;
   localparam int C2_DEBUG_N = 12;
   localparam int C2_TRIP = 10;
   localparam int C2_STACK = 9;
   localparam int C2_PLL = 8;
   localparam int C2_WRT_HI = 1;
   localparam int C2_WRT_LO = 0;
   // word two: unimplemented and reserved bits forced to one
   localparam logic [13:0] C2_FIXED_ONES = 14'h08fc;
   // blank / erased value
   localparam logic [13:0] ERASED_WORD = 14'h3fff;
   localparam logic [13:0] ZERO_WORD = 14'h0000;
   // identification, values arbitrary
   localparam logic [8:0] PART_CODE = 9'h0a5;
   localparam logic [4:0] SILICON_STEP = 5'h03;
   // two-bit mode encodings
   localparam logic [1:0] MODE_ON = 2'h3;
   localparam logic [1:0] MODE_RUN = 2'h2;
   localparam logic [1:0] MODE_SOFT = 2'h1;
   localparam logic [1:0] MODE_OFF = 2'h0;
   // clock source encodings
   localparam logic [2:0] ext_clock_high = 3'h7;
   localparam logic [2:0] ext_clock_mid = 3'h6;
   localparam logic [2:0] ext_clock_low = 3'h5;
   localparam logic [2:0] internal_osc_source = 3'h4;
   localparam logic [2:0] resistor_cap_osc = 3'h3;
   localparam logic [2:0] high_gain_crystal = 3'h2;
   localparam logic [2:0] medium_gain_crystal = 3'h1;
   localparam logic [2:0] low_power_crystal = 3'h0;
   localparam int USER_IDS = 4;
endpackage
